/* File: serial_eeprom_defs.vh */
// Purpose: constants for the two-wire serial EEPROM command engine
// Assumes: 100 MHz core clock, 8K x 8 array, 32-byte page buffer
// Notes: definitions only
`ifndef SERIAL_EEPROM_DEFS_VH
`define SERIAL_EEPROM_DEFS_VH
`define CTRL_TYPE_CODE 4'ha
`define ADDR_W 13
`define PAGE_W 5
`define BIT_ACK_CNT 4'h8
`define BIT_END_CNT 4'h9
`define KIND_CTRL 2'h0
`define KIND_ADDRH 2'h1
`define KIND_ADDRL 2'h2
`define KIND_DATA 2'h3
`define WR_TIME_NS 5000000
`define CLK_PERIOD_NS 10
`define WR_CYCLES_DEF ((`WR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: serial_eeprom_command_engine.v */
// Purpose: slave command engine of an 8K x 8 two-wire serial EEPROM
// Assumes: scl/sda and straps are asynchronous and sampled by core_clk_i;
//          scl is far slower than the core clock (several cycles per phase)
// Notes: open-drain sda: sda_o is always 0, sda_oe_n_o low pulls the line low
`timescale 1ns/1ps
`include "serial_eeprom_defs.vh"

module serial_eeprom_command_engine #(
   parameter integer WR_CYCLES = `WR_CYCLES_DEF
) (
   // clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // two-wire bus
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_n_o,
   // straps
   input wire chip_select_bit0_i,
   input wire chip_select_bit1_i,
   input wire chip_select_bit2_i,
   input wire write_protect_i,
   // status
   output reg write_busy_o
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RX = 3'b010;
   localparam [2:0] ST_TX = 3'b100;

   // operating notes, one topic per paragraph
   //
   // pin timing
   // every pin passes two flops, so bus events are seen two core clocks late
   // an scl edge is found one clock after that, by comparing with a third flop
   // a phase of scl must therefore last several core clocks or edges are lost
   // start and stop need scl high on both the current and the delayed copy
   //
   // bit framing
   // bits are shifted in on the synchronised scl rising edge, msb first
   // the bit counter runs 0..7 for data bits, is 8 after them and reaches 9 on the ack clock
   // the ack is driven on the fall that ends bit eight, released on the next
   // the device only moves sda well after an scl fall, never with scl high
   //
   // byte kinds inside a write command
   // control byte, then address high, address low, then any number of data
   // the kind stops advancing at data, so long page writes stay on data
   // only five bits of the high address byte are kept; the rest are ignored
   // the low address byte clears the slot map of the page buffer
   //
   // control byte decode
   // type code and three select bits must match, and no write may be running
   // a refused control byte gets no ack and the engine waits for a new start
   // the read/write bit is kept only when the byte is acknowledged
   // polling while busy is simply a refused control byte, repeated
   //
   // page buffer
   // data bytes land in the slot picked by the low five pointer bits
   // the slot map records which slots were written since the address load
   // more than 32 bytes overwrite the oldest slots, first in first out
   // the high pointer bits never move here, so the page can not be left
   //
   // write cycle
   // a stop with data pending and protect low starts the self-timed cycle
   // protect is read from its synchronised copy at that single edge only
   // a protected stop drops the pending data and leaves the device ready
   // the commit walk copies one slot per clock, only slots that were written
   // busy is held for the whole count and also until the walk has finished
   // limitation: counts below 33 stretch busy to the length of the walk
   //
   // reads
   // the byte at the pointer is loaded on the fall that ends the ack clock
   // the pointer steps on each load, so it always names the next location
   // a master ack on the ninth clock loads the next byte, a nack idles
   // the pointer is thirteen bits wide and rolls over inside this array
   //
   // random read
   // a repeated start after the address bytes keeps the loaded pointer
   // it clears any pending data, so no write cycle follows the later stop
   //
   // array access
   // the array is read combinationally at the pointer, at load time only
   // the commit walk and the read path never meet: reads are refused
   // while busy, so the array port is free for the walk
   //
   // reset
   // reset clears the control state and the pointer, never the array
   // the synchroniser flops reset to the idle bus level, so no false start
   // the drive enable resets high, leaving sda released to its pull-up
   //
   // trade-offs
   // one core clock domain for everything keeps the design free of crossings
   // the price is a minimum core to bus clock ratio, several clocks per phase
   // the commit walk costs 32 clocks but needs only one array write port
   // buffer and array have no reset, which keeps them plain memory arrays
   //
   // open drain
   // sda_o stays zero for ever; only the enable says whether sda is pulled
   // the master and the pull-up decide the level while the enable is high
   //
   // state codes
   // one-hot: idle waits for a start, rx takes bytes, tx sends read data
   // an illegal code falls back to idle with sda released

   // two-flop synchronisers for every pin; stage 1 feeds only stage 2
   reg [5:0] pin_s1_q;
   reg [5:0] pin_s2_q;
   reg scl_d_q;
   reg sda_d_q;
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1_q <= 6'h03;
         pin_s2_q <= 6'h03;
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         pin_s1_q <= {write_protect_i, chip_select_bit2_i, chip_select_bit1_i,
                      chip_select_bit0_i, sda_i, scl_i};
         pin_s2_q <= pin_s1_q;
         scl_d_q <= pin_s2_q[0];
         sda_d_q <= pin_s2_q[1];
      end
   end

   wire scl_s = pin_s2_q[0];
   wire sda_s = pin_s2_q[1];
   wire [2:0] cs_s = pin_s2_q[4:2];
   wire wp_s = pin_s2_q[5];

   // bus events from the synchronised copies
   wire scl_rise = scl_s & ~scl_d_q;
   wire scl_fall = ~scl_s & scl_d_q;
   wire start_ev = scl_s & scl_d_q & ~sda_s & sda_d_q;
   wire stop_ev = scl_s & scl_d_q & sda_s & ~sda_d_q;

   // storage: array and page buffer have no reset
   reg [7:0] mem [0:(1 << `ADDR_W) - 1];
   reg [7:0] page_buf [0:(1 << `PAGE_W) - 1];

   reg [2:0] state_q;
   reg [1:0] kind_q;
   reg [3:0] cnt_q;
   reg [7:0] sh_q;
   reg [`ADDR_W-1:0] ptr_q;
   reg rw_q;
   reg ack_m_q;
   reg wr_pend_q;
   reg [31:0] valid_q;
   reg [7:0] page_q;
   reg [`PAGE_W-1:0] cidx_q;
   reg commit_q;
   reg [31:0] timer_q;

   wire [7:0] rd_byte = mem[ptr_q];
   wire rx_byte_done = (state_q == ST_RX) & scl_fall & (cnt_q == `BIT_ACK_CNT);
   wire data_wr = rx_byte_done & (kind_q == `KIND_DATA);
   wire ctrl_match = (sh_q[7:4] == `CTRL_TYPE_CODE) & (sh_q[3:1] == cs_s);

   // page buffer fill; only the low five pointer bits pick the slot
   always @(posedge core_clk_i) begin
      if (data_wr) begin
         page_buf[ptr_q[`PAGE_W-1:0]] <= sh_q;
      end
   end

   // commit walks the buffer one slot per clock inside the write cycle
   always @(posedge core_clk_i) begin
      if (commit_q && valid_q[cidx_q]) begin
         mem[{page_q, cidx_q}] <= page_buf[cidx_q];
      end
   end

   // write-cycle timer and commit walk; busy held until the count expires
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         write_busy_o <= 1'b0;
         timer_q <= 32'h0;
         cidx_q <= {`PAGE_W{1'b0}};
         commit_q <= 1'b0;
         page_q <= 8'h00;
      end else if (stop_ev && wr_pend_q && !wp_s && !write_busy_o) begin
         // protect level taken here only; later toggles cannot touch it
         write_busy_o <= 1'b1;
         timer_q <= WR_CYCLES;
         cidx_q <= {`PAGE_W{1'b0}};
         commit_q <= 1'b1;
         page_q <= ptr_q[`ADDR_W-1:`PAGE_W];
      end else if (write_busy_o) begin
         if (commit_q) begin
            cidx_q <= cidx_q + 1'b1;
            commit_q <= ~(&cidx_q);
         end
         if (timer_q > 32'h1) begin
            timer_q <= timer_q - 32'h1;
         end else begin
            timer_q <= 32'h0;
            write_busy_o <= commit_q; // never drop busy before the walk ends
         end
      end
   end

   // protocol engine
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         kind_q <= `KIND_CTRL;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= {`ADDR_W{1'b0}};
         rw_q <= 1'b0;
         ack_m_q <= 1'b0;
         wr_pend_q <= 1'b0;
         valid_q <= 32'h0;
         sda_o <= 1'b0;
         sda_oe_n_o <= 1'b1;
      end else if (stop_ev) begin
         // stop ends any command; a pending write is either started or dropped
         state_q <= ST_IDLE;
         sda_oe_n_o <= 1'b1;
         wr_pend_q <= 1'b0;
         cnt_q <= 4'h0;
      end else if (start_ev) begin
         // a repeated start abandons buffered data but keeps the pointer
         state_q <= ST_RX;
         kind_q <= `KIND_CTRL;
         cnt_q <= 4'h0;
         wr_pend_q <= 1'b0;
         sda_oe_n_o <= 1'b1;
      end else begin
         case (state_q)
            ST_IDLE: begin
               sda_oe_n_o <= 1'b1;
            end
            ST_RX: begin
               if (scl_rise) begin
                  if (cnt_q < `BIT_ACK_CNT) begin
                     sh_q <= {sh_q[6:0], sda_s};
                  end
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == `BIT_ACK_CNT) begin
                  case (kind_q)
                     `KIND_CTRL: begin
                        if (ctrl_match && !write_busy_o) begin
                           sda_oe_n_o <= 1'b0;
                           rw_q <= sh_q[0];
                        end else begin
                           state_q <= ST_IDLE; // silent until next start
                        end
                     end
                     `KIND_ADDRH: begin
                        ptr_q[`ADDR_W-1:8] <= sh_q[4:0];
                        sda_oe_n_o <= 1'b0;
                     end
                     `KIND_ADDRL: begin
                        ptr_q[7:0] <= sh_q;
                        valid_q <= 32'h0;
                        sda_oe_n_o <= 1'b0;
                     end
                     default: begin
                        // data byte: slot marked, low five bits advance
                        valid_q[ptr_q[`PAGE_W-1:0]] <= 1'b1;
                        ptr_q[`PAGE_W-1:0] <= ptr_q[`PAGE_W-1:0] + 1'b1;
                        wr_pend_q <= 1'b1;
                        sda_oe_n_o <= 1'b0;
                     end
                  endcase
               end else if (scl_fall && cnt_q == `BIT_END_CNT) begin
                  cnt_q <= 4'h0;
                  if (kind_q == `KIND_CTRL && rw_q) begin
                     // read: first bit goes out on the same falling edge
                     state_q <= ST_TX;
                     sh_q <= rd_byte;
                     sda_oe_n_o <= rd_byte[7];
                     ptr_q <= ptr_q + 1'b1;
                  end else begin
                     sda_oe_n_o <= 1'b1;
                     if (kind_q != `KIND_DATA) begin
                        kind_q <= kind_q + 2'h1;
                     end
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  if (cnt_q == `BIT_ACK_CNT) begin
                     ack_m_q <= ~sda_s;
                  end
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q < `BIT_ACK_CNT) begin
                     sh_q <= {sh_q[6:0], 1'b0};
                     sda_oe_n_o <= sh_q[6];
                  end else if (cnt_q == `BIT_ACK_CNT) begin
                     sda_oe_n_o <= 1'b1; // master owns the ack slot
                  end else if (ack_m_q) begin
                     // 13-bit pointer rolls over inside this array only
                     sh_q <= rd_byte;
                     sda_oe_n_o <= rd_byte[7];
                     ptr_q <= ptr_q + 1'b1;
                     cnt_q <= 4'h0;
                  end else begin
                     state_q <= ST_IDLE;
                     sda_oe_n_o <= 1'b1;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               sda_oe_n_o <= 1'b1;
            end
         endcase
      end
   end

endmodule // serial_eeprom_command_engine

/* File: eeprom_cmd_checker.sv */
// Purpose: timing checks on the eeprom command engine pins
// Assumes: one core clock domain, open-drain sda with pull-up
// Notes: bound into the engine from the bench top file
`timescale 1ns/1ps
module eeprom_cmd_checker #(
   parameter integer WR_CYCLES = 64
) (
   // clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // bus, strap and status
   input wire scl_i,
   input wire sda_i,
   input wire sda_o,
   input wire sda_oe_n_o,
   input wire write_protect_i,
   input wire write_busy_o
);
   reg sda_q;
   reg wp_q;
   reg [3:0] age_q;
   reg [19:0] len_q;
   // stop seen on raw pins; protect level kept from that stop, busy length counted
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sda_q <= 1'b1;
         wp_q <= 1'b0;
         age_q <= 4'hf;
         len_q <= 20'h0;
      end else begin
         sda_q <= sda_i;
         len_q <= write_busy_o ? len_q + 20'h1 : 20'h0;
         if (scl_i && sda_i && !sda_q) begin
            wp_q <= write_protect_i;
            age_q <= 4'h0;
         end else if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
         end
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_drive_zero: assert property (!sda_oe_n_o |-> !sda_o)
      else $error("sda driven high");
   a_reset_quiet: assert property ($rose(rst_n_i) |-> sda_oe_n_o && !write_busy_o)
      else $error("active after reset");
   a_busy_silent: assert property (write_busy_o |-> sda_oe_n_o)
      else $error("drive during write cycle");
   a_busy_after_stop: assert property ($rose(write_busy_o) |-> age_q <= 4'h6)
      else $error("write cycle without stop");
   a_wp_blocks: assert property ($rose(write_busy_o) |-> !wp_q)
      else $error("protected write started");
   a_busy_length: assert property ($fell(write_busy_o) |-> len_q == WR_CYCLES)
      else $error("write cycle length wrong");
   a_busy_bounded: assert property (write_busy_o |-> len_q < WR_CYCLES)
      else $error("write cycle too long");
   a_edge_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
      else $error("sda changed with scl high");
   a_ack_stands: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*8])
      else $error("low bit too short");
   c_write: cover property ($rose(write_busy_o));
   c_drive: cover property ($fell(sda_oe_n_o));
   c_wp_stop: cover property (scl_i && $rose(sda_i) && write_protect_i);
endmodule // eeprom_cmd_checker

/* File: two_wire_master.sv */
// Purpose: behavioural two-wire bus master for the bench
// Assumes: 16 core clocks per bus clock, phases of 4 clocks
// Notes: sda_o high means released; the bench adds the pull-up
`timescale 1ns/1ps
module two_wire_master (
   // clock
   input wire core_clk_i,
   // bus
   input wire sda_i,
   output reg scl_o,
   output reg sda_o
);
   // bus idle high from time zero
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // set both lines, then hold them a quarter bus clock
   task ph(input c, input s);
      scl_o <= c;
      sda_o <= s;
      repeat (4) @(posedge core_clk_i);
   endtask
   // start or repeated start; sda rises only while scl is low
   task start();
      ph(scl_o, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
      ph(1'b0, 1'b0);
   endtask
   task stop();
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b1);
   endtask
   // eight bits msb first, then the ninth clock; sda only moves with scl low
   task byte_x(input [7:0] o, input a_in, output [7:0] got, output a_out);
      integer i;
      for (i = 7; i >= -1; i = i - 1) begin
         ph(1'b0, i < 0 ? a_in : o[i]);
         ph(1'b1, sda_o);
         ph(1'b1, sda_o);
         if (i >= 0) got[i] = sda_i;
         else a_out = sda_i;
         ph(1'b0, sda_o);
      end
   endtask
endmodule // two_wire_master

/* File: serial_eeprom_command_engine_tb.sv */
// Purpose: self-checking bench for the eeprom command engine
// Assumes: 100 MHz core clock, 160 ns bus clock from the master model
// Notes: the array has no reset, so every byte read back is written first
`timescale 1ns/1ps
module serial_eeprom_command_engine_tb;
   localparam [2:0] SEL = 3'h5;
   // clock, reset and protect strap
   reg core_clk_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg wp = 1'b0;
   wire scl, m_sda, sda_o, sda_oe_n, busy;
   // open-drain line with pull-up: low when either side pulls
   wire sda_w = sda_oe_n ? m_sda : 1'b0;
   integer fail_count = 0;
   integer n_tests = 0;
   reg r;
   reg [7:0] d;
   always #5 core_clk_i = ~core_clk_i;
   // write time long enough that the first two polls fall inside it
   serial_eeprom_command_engine #(.WR_CYCLES(400)) dut (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
      .chip_select_bit0_i(SEL[0]), .chip_select_bit1_i(SEL[1]),
      .chip_select_bit2_i(SEL[2]), .write_protect_i(wp), .write_busy_o(busy));
   two_wire_master m (.core_clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
   task chk(input [7:0] got, input [7:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task ctrl(input [3:0] ty, input [2:0] s, input rw, input e);
      m.start();
      m.byte_x({ty, s, rw}, 1'b1, d, r);
      chk({7'h00, ~r}, {7'h00, e});
   endtask
   // address high, address low, then n data bytes counting up from v
   task wr(input [15:0] a, input [7:0] v, input integer n);
      integer i;
      ctrl(4'ha, SEL, 1'b0, 1'b1);
      for (i = -2; i < n; i = i + 1) begin
         m.byte_x(i == -2 ? a[15:8] : i == -1 ? a[7:0] : v + i[7:0], 1'b1, d, r);
         chk(!r, 1'b1);
      end
   endtask
   // stop, move the strap after it, then poll until acked
   task poll(input bz, input nwp);
      integer k;
      m.stop();
      wp <= nwp;
      repeat (8) @(posedge core_clk_i);
      chk({7'h00, busy}, {7'h00, bz});
      r = 1'b1;
      for (k = 0; k < 6 && r !== 1'b0; k = k + 1) begin
         m.start();
         m.byte_x({4'ha, SEL, 1'b0}, 1'b1, d, r);
      end
      chk(k[7:0], bz ? 8'h03 : 8'h01);
      m.stop();
   endtask
   // current read of one byte, or random read of two
   task rd(input rnd, input [15:0] a, input [7:0] e0, input [7:0] e1);
      if (rnd) wr(a, 8'h00, 0);
      ctrl(4'ha, SEL, 1'b1, 1'b1);
      m.byte_x(8'hff, !rnd, d, r);
      chk(d, e0);
      if (rnd) m.byte_x(8'hff, 1'b1, d, r);
      if (rnd) chk(d, e1);
      m.stop();
   endtask
   task test_select();
      integer k;
      ctrl(4'hb, SEL, 1'b0, 1'b0);
      for (k = 0; k < 3; k = k + 1) ctrl(4'ha, SEL ^ (3'h1 << k), k[0], 1'b0);
      wr(16'h0000, 8'h00, 0);
      poll(1'b0, 1'b0);
      $display("test select done");
   endtask
   task test_byte();
      wr(16'h0001, 8'h77, 1);
      poll(1'b1, 1'b0);
      wr(16'h0000, 8'h3c, 1);
      poll(1'b1, 1'b0);
      rd(1'b0, 16'h0, 8'h77, 8'h0);
      wr(16'h1fff, 8'ha5, 1);
      poll(1'b1, 1'b1);
      rd(1'b1, 16'h1fff, 8'ha5, 8'h3c);
      wr(16'h0001, 8'h99, 1);
      poll(1'b0, 1'b0);
      rd(1'b1, 16'h0000, 8'h3c, 8'h77);
      $display("test byte done");
   endtask
   // 35 bytes from slot 30: wraps in the page and overwrites the first slots
   task test_page();
      wr(16'he17e, 8'h40, 35);
      poll(1'b1, 1'b0);
      rd(1'b0, 16'h0, 8'h43, 8'h0);
      rd(1'b1, 16'h017e, 8'h60, 8'h61);
      rd(1'b1, 16'h0160, 8'h62, 8'h43);
      rd(1'b0, 16'h0, 8'h44, 8'h0);
      $display("test page done");
   endtask
   task give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // reset, then the tests in order
   initial begin
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      repeat (8) @(posedge core_clk_i);
      test_select();
      test_byte();
      test_page();
      give_verdict();
   end
   // watchdog: the tests need about a fifth of this span
   initial begin
      #800000;
      fail_count = fail_count + 1;
      give_verdict();
   end
endmodule // serial_eeprom_command_engine_tb
bind serial_eeprom_command_engine eeprom_cmd_checker #(.WR_CYCLES(WR_CYCLES)) chk_i (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o), .write_protect_i(write_protect_i), .write_busy_o(write_busy_o));
